// >>> common/smflc_pkg.sv
/*
  Shared constants and carrier types for the port-2 modem line flow control block.
  Assumes a single 250 MHz system clock and a plain strobe register port.
*/
package smflc_pkg;

  // ****************************************************************
  // Register map (word addresses on the plain port)
  // ****************************************************************
  localparam logic [3:0] SMFLC_ADDR_DSR_OPT = 4'h0; // dsr_flow_option
  localparam logic [3:0] SMFLC_ADDR_DTR_OPT = 4'h1; // dtr_output_option
  localparam logic [3:0] SMFLC_ADDR_LINE_STAT = 4'h2; // line_signal_status
  localparam logic [3:0] SMFLC_ADDR_CTRL = 4'h3; // mode, run, rx enable
  localparam logic [3:0] SMFLC_ADDR_TX_STAT = 4'h4; // transmit status code
  localparam logic [3:0] SMFLC_ADDR_IRQ_STAT = 4'h5; // sticky events, write one to clear
  localparam logic [3:0] SMFLC_ADDR_IRQ_MASK = 4'h6; // interrupt mask

  // ****************************************************************
  // Reset values and field positions
  // ****************************************************************
  localparam logic [15:0] SMFLC_OPT_RESET = 16'h0000;
  localparam logic [15:0] SMFLC_CTRL_RESET = 16'h0000;
  localparam int SMFLC_CTRL_RUN_BIT = 0;
  localparam int SMFLC_CTRL_RXEN_BIT = 1;
  localparam int SMFLC_CTRL_MAINT_BIT = 2;
  localparam int SMFLC_CTRL_PORT2_BIT = 3;
  localparam int SMFLC_IRQ_W = 3;
  localparam int SMFLC_IRQ_TIMEOUT_BIT = 0;
  localparam int SMFLC_IRQ_DSR_CHG_BIT = 1;
  localparam int SMFLC_IRQ_STAT_UPD_BIT = 2;
  localparam logic [15:0] SMFLC_TXERR_NONE = 16'h0000;
  localparam logic [15:0] SMFLC_TXERR_BUSY_TIMEOUT = 16'h0001;

  // ****************************************************************
  // Option encodings
  // ****************************************************************
  localparam logic [15:0] SMFLC_DSR_NONE = 16'h0000;
  localparam logic [15:0] SMFLC_DSR_ON_TXRX = 16'h0001;
  localparam logic [15:0] SMFLC_DSR_OFF_TXRX = 16'h0002;
  localparam logic [15:0] SMFLC_DSR_ON_TX = 16'h0003;
  localparam logic [15:0] SMFLC_DSR_OFF_TX = 16'h0004;
  localparam logic [15:0] SMFLC_DTR_RUN = 16'h0000;
  localparam logic [15:0] SMFLC_DTR_OFF = 16'h0001;
  localparam logic [15:0] SMFLC_DTR_RX = 16'h0002;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam longint SMFLC_CLK_HZ = 250000000;
  localparam longint SMFLC_BUSY_TIMEOUT_MS = 5000;
  // Longest wait rounds down
  localparam longint SMFLC_BUSY_TIMEOUT_CYC = SMFLC_CLK_HZ / 1000 * SMFLC_BUSY_TIMEOUT_MS;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } smflc_bus_req_t;

  typedef struct packed {
    logic tx_busy;   // Transmitter has data pending
    logic tx_permit; // Transmit may proceed
    logic rx_permit; // Receive may proceed
    logic tx_abort;  // One-cycle abort of the transfer
  } smflc_flow_t;

endpackage : smflc_pkg

// >>> rtl/smflc_busy_timer.sv
/*
  Busy-timeout counter: counts while transmission is held off.
  Assumes synchronous inputs on the system clock.
*/
`timescale 1ns/1ps
module smflc_busy_timer #(
  parameter longint LIMIT = 64'd1250000000
) (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic stall_in,
  output logic expire_out
);
  import smflc_pkg::*;

  localparam int CW = $clog2(LIMIT + 1);

  initial begin
    if (LIMIT < 2) $error("LIMIT too small");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic fired;
  } smflc_tmr_t;

  smflc_tmr_t s_q, s_d;

  // Count up while stalled; one pulse at the limit, then hold
  always_comb begin
    s_d = s_q;
    expire_out = 1'b0;
    if (!stall_in) begin
      s_d.cnt = '0;
      s_d.fired = 1'b0;
    end else if (!s_q.fired) begin
      if (s_q.cnt == CW'(LIMIT - 1)) begin
        expire_out = 1'b1;
        s_d.fired = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 1'b1;
      end
    end
  end

  // Register the state
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : smflc_busy_timer

// >>> rtl/smflc_line_ctrl.sv
/*
  Port-2 modem line flow control: DSR gating, DTR drive, RTS, line status,
  busy timeout and interrupt. Registers sit on a plain strobe port.
  Assumes synchronous DSR input and a one-cycle end-of-scan pulse.
*/
`timescale 1ns/1ps

//
// Contract
// RL1 - DTR option 0 or 3+: follows run
// RL2 - DTR option 1: DTR always off
// RL3 - DTR option 2: on while receive possible
// RL4 - DSR option 0: DSR ignored
// RL5 - DSR option 1: tx/rx only when on
// RL6 - DSR option 2: tx/rx only when off
// RL7 - DSR option 3: transmit only when on
// RL8 - DSR option 4: transmit only when off
// RL9 - DSR option 5+: same as 0
// RL10 - Busy over 5 s aborts, logs error
// RL11 - Options apply to port 2 user mode
// RL12 - Far terminal signals readiness on DSR
// RL13 - Maintenance mode: DTR always on
// RL14 - Line status: bit0 DTR, bit1 DSR
// RL15 - Line status refreshed at end of scan
// RL16 - RTS held permanently on
module smflc_line_ctrl #(
  parameter longint BUSY_TIMEOUT_CYC = smflc_pkg::SMFLC_BUSY_TIMEOUT_CYC
) (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire smflc_pkg::smflc_bus_req_t bus_in,
  output logic [15:0] rdata_out,
  input wire logic dsr_in,
  input wire logic scan_end_in,
  input wire logic tx_busy_in,
  output logic dtr_out,
  output logic rts_out,
  output smflc_pkg::smflc_flow_t flow_out,
  output logic irq_out
);
  import smflc_pkg::*;

  initial begin
    if (BUSY_TIMEOUT_CYC < 2) $error("BUSY_TIMEOUT_CYC too small");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [1:0] {
    SMFLC_TX_IDLE = 2'b00,
    SMFLC_TX_SEND = 2'b01,
    SMFLC_TX_HOLD = 2'b11
  } smflc_tx_st_t;

  typedef struct packed {
    logic [15:0] dsr_opt;
    logic [15:0] dtr_opt;
    logic [15:0] ctrl;
    logic [15:0] tx_stat;
    logic [1:0] line_stat;
    logic [SMFLC_IRQ_W-1:0] irq_stat;
    logic [SMFLC_IRQ_W-1:0] irq_mask;
    logic [15:0] rdata;
    logic dtr;
    logic dsr_prev;
    smflc_tx_st_t tx_st;
  } smflc_state_t;

  smflc_state_t s_q, s_d;

  // Decoded conditions
  logic run, rxen, maint, port2_user, rx_possible;
  logic tx_ok, rx_ok, stall, expire;
  logic [SMFLC_IRQ_W-1:0] ev;

  assign run = s_q.ctrl[SMFLC_CTRL_RUN_BIT];
  assign rxen = s_q.ctrl[SMFLC_CTRL_RXEN_BIT];
  assign maint = s_q.ctrl[SMFLC_CTRL_MAINT_BIT];
  // Options only matter for port 2 in user mode
  assign port2_user = s_q.ctrl[SMFLC_CTRL_PORT2_BIT] && !maint; // RL11

  // ****************************************************************
  // DSR gating
  // ****************************************************************
  // Stopped: tx and rx disabled in user mode regardless of DSR
  always_comb begin
    tx_ok = run || maint;
    rx_ok = run || maint;
    if (port2_user) begin
      case (s_q.dsr_opt)
        SMFLC_DSR_ON_TXRX: begin
          tx_ok = run && dsr_in; // RL5
          rx_ok = run && dsr_in; // RL5
        end
        SMFLC_DSR_OFF_TXRX: begin
          tx_ok = run && !dsr_in; // RL6
          rx_ok = run && !dsr_in; // RL6
        end
        SMFLC_DSR_ON_TX: begin
          tx_ok = run && dsr_in; // RL7 RL12
        end
        SMFLC_DSR_OFF_TX: begin
          tx_ok = run && !dsr_in; // RL8
        end
        default: begin
          // Zero and five upward leave DSR unused
          tx_ok = run; // RL4 RL9
          rx_ok = run; // RL4 RL9
        end
      endcase
    end
  end

  // Receive needs both the DSR gate and the receive enable bit
  // DTR option 2 reads this, so DTR drops whenever reception is blocked
  assign rx_possible = rx_ok && rxen;

  // Timeout only runs in busy control while data waits
  // Options 1 and 2 block without a limit; the link simply waits
  assign stall = port2_user && tx_busy_in && !tx_ok && run &&
                 (s_q.dsr_opt == SMFLC_DSR_ON_TX || s_q.dsr_opt == SMFLC_DSR_OFF_TX);

  smflc_busy_timer #(
    .LIMIT(BUSY_TIMEOUT_CYC)
  ) u_timer (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .stall_in(stall),
    .expire_out(expire)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    s_d.rdata = 16'h0000;
    s_d.dsr_prev = dsr_in;
    // DTR drive, registered so the pin never glitches on option writes
    if (maint) begin
      s_d.dtr = 1'b1; // RL13
    end else if (!port2_user) begin
      // Options unused off port 2 user mode: DTR shows run state
      s_d.dtr = run; // RL11
    end else begin
      case (s_q.dtr_opt)
        SMFLC_DTR_OFF: s_d.dtr = 1'b0; // RL2
        SMFLC_DTR_RX: s_d.dtr = rx_possible; // RL3
        default: s_d.dtr = run; // RL1
      endcase
    end
    // Transmit flow state
    // Hold tracks a paused transfer; a timeout drops it back to idle
    case (s_q.tx_st)
      SMFLC_TX_IDLE: if (tx_busy_in) s_d.tx_st = SMFLC_TX_SEND;
      SMFLC_TX_SEND: begin
        if (!tx_busy_in) s_d.tx_st = SMFLC_TX_IDLE;
        else if (!tx_ok) s_d.tx_st = SMFLC_TX_HOLD;
      end
      SMFLC_TX_HOLD: begin
        if (expire || !tx_busy_in) s_d.tx_st = SMFLC_TX_IDLE; // RL10
        else if (tx_ok) s_d.tx_st = SMFLC_TX_SEND;
      end
      default: s_d.tx_st = SMFLC_TX_IDLE;
    endcase
    if (expire) begin
      s_d.tx_stat = SMFLC_TXERR_BUSY_TIMEOUT; // RL10
    end
    // Line status at end of scan
    // Sampled from the registered DTR, so the value matches the pin
    if (scan_end_in) begin
      s_d.line_stat = {dsr_in, s_q.dtr}; // RL14 RL15
    end
    // Register writes
    // Status registers take no data, only the clears below
    if (bus_in.wr) begin
      case (bus_in.addr)
        SMFLC_ADDR_DSR_OPT: s_d.dsr_opt = bus_in.wdata;
        SMFLC_ADDR_DTR_OPT: s_d.dtr_opt = bus_in.wdata;
        SMFLC_ADDR_CTRL: s_d.ctrl = bus_in.wdata;
        SMFLC_ADDR_TX_STAT: if (!expire) s_d.tx_stat = SMFLC_TXERR_NONE;
        SMFLC_ADDR_IRQ_STAT: s_d.irq_stat = s_q.irq_stat & ~bus_in.wdata[SMFLC_IRQ_W-1:0];
        SMFLC_ADDR_IRQ_MASK: s_d.irq_mask = bus_in.wdata[SMFLC_IRQ_W-1:0];
        default: ;
      endcase
    end
    // Events set after clears so a set wins
    s_d.irq_stat = s_d.irq_stat | ev;
    // Register reads, unmapped reads zero
    // Read data lives one cycle, then falls back to zero
    if (bus_in.rd) begin
      case (bus_in.addr)
        SMFLC_ADDR_DSR_OPT: s_d.rdata = s_q.dsr_opt;
        SMFLC_ADDR_DTR_OPT: s_d.rdata = s_q.dtr_opt;
        SMFLC_ADDR_LINE_STAT: s_d.rdata = {14'h0000, s_q.line_stat}; // RL14
        SMFLC_ADDR_CTRL: s_d.rdata = s_q.ctrl;
        SMFLC_ADDR_TX_STAT: s_d.rdata = s_q.tx_stat;
        SMFLC_ADDR_IRQ_STAT: s_d.rdata = {13'h0000, s_q.irq_stat};
        SMFLC_ADDR_IRQ_MASK: s_d.rdata = {13'h0000, s_q.irq_mask};
        default: s_d.rdata = 16'h0000;
      endcase
    end
  end

  // Event vector
  // DSR edge uses the previous sample, reset low like the idle pin
  always_comb begin
    ev = '0;
    ev[SMFLC_IRQ_TIMEOUT_BIT] = expire;
    ev[SMFLC_IRQ_DSR_CHG_BIT] = dsr_in ^ s_q.dsr_prev;
    ev[SMFLC_IRQ_STAT_UPD_BIT] = scan_end_in;
  end

  // Register the whole state
  // Reset leaves the port stopped, in user mode, options zero
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_q <= '{dsr_opt: SMFLC_OPT_RESET, dtr_opt: SMFLC_OPT_RESET,
               ctrl: SMFLC_CTRL_RESET, tx_stat: SMFLC_TXERR_NONE,
               line_stat: 2'h0, irq_stat: '0, irq_mask: '0, rdata: 16'h0000,
               dtr: 1'b0, dsr_prev: 1'b0, tx_st: SMFLC_TX_IDLE};
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rdata_out = s_q.rdata;
  assign dtr_out = s_q.dtr;
  assign rts_out = 1'b1; // RL16
  // Permits are combinational so a DSR drop stops the next character
  assign flow_out.tx_busy = tx_busy_in;
  assign flow_out.tx_permit = tx_ok && (s_q.tx_st != SMFLC_TX_HOLD || tx_ok);
  assign flow_out.rx_permit = rx_possible;
  assign flow_out.tx_abort = expire; // RL10
  // Level interrupt from registers only, so it cannot glitch
  assign irq_out = |(s_q.irq_stat & s_q.irq_mask);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // DTR checks: dtr_out is registered, so it lags its cause by one cycle
  a_dtr_off_opt: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // RL2
    (s_q.dtr_opt == SMFLC_DTR_OFF && port2_user) |=> !dtr_out)
    else $error("DTR on with option one");
  // Option two follows the receive gate of the previous cycle
  a_dtr_rx_opt: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // RL3
    (s_q.dtr_opt == SMFLC_DTR_RX && port2_user) |=> (dtr_out == $past(rx_possible)))
    else $error("DTR not following receive");
  // Zero, three up and port 1 outside maintenance show the run state
  a_dtr_run_opt: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // RL1
    (!maint && (!port2_user || s_q.dtr_opt == 16'h0000 || s_q.dtr_opt >= 16'h0003))
    |=> (dtr_out == $past(run)))
    else $error("DTR not following run");
  a_dtr_maint_on: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // RL13
    maint |=> dtr_out)
    else $error("DTR off in maintenance");
  // Maintenance leaves traffic free of the DSR gate
  a_maint_traffic: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // RL13
    maint |-> flow_out.tx_permit && (flow_out.rx_permit == rxen))
    else $error("Traffic gated in maintenance");

  // DSR gating checks are combinational: permits follow dsr_in at once
  a_dsr_ignored: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // RL4
    (port2_user && s_q.dsr_opt == SMFLC_DSR_NONE) |->
    (flow_out.tx_permit == run) && (flow_out.rx_permit == (run && rxen)))
    else $error("DSR used with option zero");
  a_dsr_on_gate: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // RL5
    (port2_user && s_q.dsr_opt == SMFLC_DSR_ON_TXRX && !dsr_in) |->
    !flow_out.tx_permit && !flow_out.rx_permit)
    else $error("Traffic with DSR off");
  a_dsr_off_gate: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // RL6
    (port2_user && s_q.dsr_opt == SMFLC_DSR_OFF_TXRX && dsr_in) |->
    !flow_out.tx_permit && !flow_out.rx_permit)
    else $error("Traffic with DSR on");
  a_busy_tx_gate: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // RL7
    (port2_user && s_q.dsr_opt == SMFLC_DSR_ON_TX && run) |-> (flow_out.tx_permit == dsr_in))
    else $error("Busy control gate wrong");
  // Option four is busy control with the DSR sense inverted
  a_busy_off_gate: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // RL8
    (port2_user && s_q.dsr_opt == SMFLC_DSR_OFF_TX && run) |-> (flow_out.tx_permit == !dsr_in))
    else $error("Inverted busy gate wrong");
  // Busy control never touches the receive side
  a_busy_rx_free: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // RL7
    (port2_user && (s_q.dsr_opt == SMFLC_DSR_ON_TX || s_q.dsr_opt == SMFLC_DSR_OFF_TX))
    |-> (flow_out.rx_permit == (run && rxen)))
    else $error("Busy control gated receive");
  a_dsr_unused: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // RL9
    (port2_user && s_q.dsr_opt >= 16'h0005) |-> (flow_out.tx_permit == run))
    else $error("DSR used with option five up");
  // Off port 2 user mode no option reaches the permits
  a_port1_free: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // RL11
    (!s_q.ctrl[SMFLC_CTRL_PORT2_BIT] && !maint) |->
    (flow_out.tx_permit == run) && (flow_out.rx_permit == (run && rxen)))
    else $error("Option used off port 2");

  // Timeout and status checks
  a_timeout_err: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // RL10
    expire |=> (s_q.tx_stat == SMFLC_TXERR_BUSY_TIMEOUT) && s_q.irq_stat[SMFLC_IRQ_TIMEOUT_BIT])
    else $error("Timeout not logged");
  // The abort is one pulse per stall, never a level
  a_abort_pulse: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // RL10
    flow_out.tx_abort |=> !flow_out.tx_abort)
    else $error("Abort longer than one cycle");
  // Only busy control can time out
  a_abort_busy: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // RL10
    flow_out.tx_abort |-> port2_user &&
    (s_q.dsr_opt == SMFLC_DSR_ON_TX || s_q.dsr_opt == SMFLC_DSR_OFF_TX))
    else $error("Abort outside busy control");
  // The error code stays until software clears it
  a_timeout_sticky: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // RL10
    (s_q.tx_stat == SMFLC_TXERR_BUSY_TIMEOUT &&
    !(bus_in.wr && bus_in.addr == SMFLC_ADDR_TX_STAT))
    |=> (s_q.tx_stat == SMFLC_TXERR_BUSY_TIMEOUT))
    else $error("Timeout code lost");
  // Capture takes DSR and the registered DTR of the scan-end cycle
  a_status_capture: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // RL14
    scan_end_in |=> (s_q.line_stat == {$past(dsr_in), $past(dtr_out)}))
    else $error("Line status capture wrong");
  a_status_scan: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // RL15
    !scan_end_in |=> $stable(s_q.line_stat))
    else $error("Line status changed off scan end");
  a_rts_on: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // RL16
    rts_out)
    else $error("RTS dropped");

  // ****************************************************************
  // Cover points
  // ****************************************************************
  c_timeout: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in) expire);
  c_hold_resume: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    s_q.tx_st == SMFLC_TX_HOLD ##1 s_q.tx_st == SMFLC_TX_SEND);
  c_irq: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in) irq_out);
  // DTR held on by maintenance while stopped
  c_maint_stop: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    maint && !run && dtr_out);
  // Scan end with both lines on
  c_scan_both: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    scan_end_in ##1 s_q.line_stat == 2'h3);

endmodule : smflc_line_ctrl

// >>> verification/smflc_remote_term.sv
/*
  Remote terminal model (a printer) that drives the DSR line.
  Assumes the bench commands busy and slow on the system clock.
*/
`timescale 1ns/1ps
module smflc_remote_term (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic busy_in,
  input wire logic slow_in,
  output logic dsr_out
);
  // Extra stage so that a slow terminal reacts one cycle late
  logic lag_q;
  // ****************************************************************
  // DSR drive
  // ****************************************************************
  // DSR on while ready, off while busy, so its buffer cannot overflow
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lag_q <= 1'b0;
      dsr_out <= 1'b0;
    end else begin
      lag_q <= !busy_in;
      dsr_out <= slow_in ? lag_q : !busy_in;
    end
  end
endmodule : smflc_remote_term

// >>> verification/smflc_line_ctrl_test.sv
/*
  Self-checking bench for the port-2 modem line flow control block.
  Assumes the plain strobe register port and a short busy timeout.
*/
`timescale 1ns/1ps
module smflc_line_ctrl_test;
  import smflc_pkg::*;
  localparam longint TMO = 20; // Short timeout keeps the run brief
  logic clk_sys_in = 1'b0;
  logic arst_n_in = 1'b0;
  smflc_bus_req_t bus = '0;
  logic [15:0] rdata;
  logic dsr, dtr, rts, irq;
  logic scan = 1'b0;
  logic txb = 1'b0;
  logic busy = 1'b1;
  logic slow = 1'b0;
  smflc_flow_t flow;
  int errors = 0;
  int checked = 0;
  int n, o, d, c;
  logic [31:0] seed = 32'h000021D1;
  logic [31:0] r;

  smflc_line_ctrl #(.BUSY_TIMEOUT_CYC(TMO)) uut (.clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in), .bus_in(bus), .rdata_out(rdata), .dsr_in(dsr),
    .scan_end_in(scan), .tx_busy_in(txb), .dtr_out(dtr), .rts_out(rts),
    .flow_out(flow), .irq_out(irq));
  smflc_remote_term term (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
    .busy_in(busy), .slow_in(slow), .dsr_out(dsr));

  // 250 MHz clock
  always #2 clk_sys_in = !clk_sys_in;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  // Transmit gate per DSR option, run assumed
  function automatic logic tx_exp(int op, logic ds);
    if (op == 1 || op == 3) return ds;
    if (op == 2 || op == 4) return !ds;
    return 1'b1;
  endfunction : tx_exp
  // Receive gate: only options 1 and 2 touch it
  function automatic logic rx_exp(int op, logic ds);
    if (op == 1) return ds;
    if (op == 2) return !ds;
    return 1'b1;
  endfunction : rx_exp
  // DTR per option, DSR option 0 assumed
  function automatic logic dtr_exp(int op, logic run, logic rxen);
    if (op == 1) return 1'b0;
    if (op == 2) return run & rxen;
    return run;
  endfunction : dtr_exp
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys_in);
    #1;
  endtask : tick
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_sys_in);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_in);
    bus <= '0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_sys_in);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_in);
    bus <= '0;
    #1;
    chk("rdata", e, rdata);
  endtask : rd
  task automatic set_busy(input logic b);
    @(posedge clk_sys_in);
    busy <= b;
    tick(3);
  endtask : set_busy
  task automatic close_out();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  // Watchdog, far beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    errors++;
    close_out();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (2) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    // Reset values, unmapped place ignored
    for (n = 0; n < 7; n++) begin
      rd(4'(n), 16'h0000);
    end
    chk("rts", 16'h0001, 16'(rts));
    chk("dtr_stop", 16'h0000, 16'(dtr));
    chk("irq_rst", 16'h0000, 16'(irq));
    wr(4'h9, 16'hFFFF);
    rd(4'h9, 16'h0000);
    // Stopped: all traffic held off
    wr(SMFLC_ADDR_CTRL, 16'h0008);
    wr(SMFLC_ADDR_DSR_OPT, 16'h0001);
    set_busy(1'b0);
    chk("tx_stop", 16'h0000, 16'(flow.tx_permit));
    // Every DSR option against both DSR levels
    wr(SMFLC_ADDR_CTRL, 16'h000B);
    for (o = 0; o < 7; o++) begin
      wr(SMFLC_ADDR_DSR_OPT, 16'(o));
      for (d = 0; d < 2; d++) begin
        set_busy(!d[0]);
        chk("tx", 16'(tx_exp(o, d[0])), 16'(flow.tx_permit));
        chk("rx", 16'(rx_exp(o, d[0])), 16'(flow.rx_permit));
      end
    end
    // Every DTR option in stop, run, run with receive
    wr(SMFLC_ADDR_DSR_OPT, 16'h0000);
    for (o = 0; o < 5; o++) begin
      for (n = 0; n < 4; n++) begin
        c = (n == 0) ? 8 : (n == 1) ? 9 : (n == 2) ? 11 : 10;
        wr(SMFLC_ADDR_DTR_OPT, 16'(o));
        wr(SMFLC_ADDR_CTRL, 16'(c));
        tick(2);
        chk("dtr", 16'(dtr_exp(o, c[0], c[1])), 16'(dtr));
      end
    end
    // Maintenance: DTR on, stopped or running
    wr(SMFLC_ADDR_DTR_OPT, 16'h0001);
    wr(SMFLC_ADDR_CTRL, 16'h000C);
    tick(2);
    chk("dtr_maint", 16'h0001, 16'(dtr));
    wr(SMFLC_ADDR_CTRL, 16'h000D);
    tick(2);
    chk("dtr_maint_run", 16'h0001, 16'(dtr));
    chk("tx_maint", 16'h0001, 16'(flow.tx_permit));
    // Port 1 in user mode: options have no effect
    wr(SMFLC_ADDR_DSR_OPT, 16'h0001);
    set_busy(1'b1);
    wr(SMFLC_ADDR_CTRL, 16'h0001);
    tick(2);
    chk("tx_port1", 16'h0001, 16'(flow.tx_permit));
    chk("dtr_port1", 16'h0001, 16'(dtr));
    // Line status captured only at end of scan
    wr(SMFLC_ADDR_DSR_OPT, 16'h0000);
    wr(SMFLC_ADDR_DTR_OPT, 16'h0000);
    wr(SMFLC_ADDR_CTRL, 16'h000B);
    for (d = 0; d < 2; d++) begin
      set_busy(!d[0]);
      @(posedge clk_sys_in);
      scan <= 1'b1;
      @(posedge clk_sys_in);
      scan <= 1'b0;
      rd(SMFLC_ADDR_LINE_STAT, 16'(2 * d + 1));
    end
    set_busy(1'b1);
    rd(SMFLC_ADDR_LINE_STAT, 16'h0003);
    // Busy timeout with a slow terminal, then the interrupt path
    slow <= 1'b1;
    wr(SMFLC_ADDR_DSR_OPT, 16'h0003);
    wr(SMFLC_ADDR_IRQ_MASK, 16'h0001);
    wr(SMFLC_ADDR_IRQ_STAT, 16'h0007);
    @(posedge clk_sys_in);
    txb <= 1'b1;
    n = 0;
    tick(1);
    while (flow.tx_abort !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    chk("abort_cyc", 16'h0001, 16'(n >= TMO - 2 && n <= TMO + 2));
    chk("tx_busy", 16'h0001, 16'(flow.tx_busy));
    c = 0;
    for (d = 0; d < 40; d++) begin
      tick(1);
      c += int'(flow.tx_abort === 1'b1);
    end
    chk("abort_once", 16'h0000, 16'(c));
    @(posedge clk_sys_in);
    txb <= 1'b0;
    rd(SMFLC_ADDR_TX_STAT, SMFLC_TXERR_BUSY_TIMEOUT);
    rd(SMFLC_ADDR_IRQ_STAT, 16'h0001);
    chk("irq_on", 16'h0001, 16'(irq));
    wr(SMFLC_ADDR_IRQ_MASK, 16'h0000);
    tick(1);
    chk("irq_masked", 16'h0000, 16'(irq));
    wr(SMFLC_ADDR_IRQ_MASK, 16'h0001);
    wr(SMFLC_ADDR_IRQ_STAT, 16'h0001);
    tick(1);
    chk("irq_clear", 16'h0000, 16'(irq));
    wr(SMFLC_ADDR_TX_STAT, 16'h0000);
    rd(SMFLC_ADDR_TX_STAT, SMFLC_TXERR_NONE);
    // Random options against random terminal behaviour
    for (d = 0; d < 12; d++) begin
      r = xs();
      wr(SMFLC_ADDR_DSR_OPT, 16'(r[2:0]));
      slow <= r[4];
      set_busy(r[3]);
      chk("tx_rand", 16'(tx_exp(int'(r[2:0]), !r[3])), 16'(flow.tx_permit));
      chk("rx_rand", 16'(rx_exp(int'(r[2:0]), !r[3])), 16'(flow.rx_permit));
    end
    // Reset in mid-run returns the options to zero
    @(posedge clk_sys_in);
    arst_n_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    rd(SMFLC_ADDR_DSR_OPT, SMFLC_OPT_RESET);
    rd(SMFLC_ADDR_DTR_OPT, SMFLC_OPT_RESET);
    chk("dtr_rst", 16'h0000, 16'(dtr));
    close_out();
  end
endmodule : smflc_line_ctrl_test
